// ===== tmc_map.vh
// register map, field positions and reset values of the waveform timer
`ifndef TMC_MAP_VH
`define TMC_MAP_VH

// byte offsets on the apb bus
`define TMC_WOC_OFS 8'h24
`define TMC_CTL_OFS 8'h28
`define TMC_CNT_OFS 8'h2C
`define TMC_CMPA_OFS 8'h30
`define TMC_CMPB_OFS 8'h34
`define TMC_FLG_OFS 8'h38
`define TMC_DIR_OFS 8'h3C

// waveform_output_control fields
`define TMC_COMA_HI 7
`define TMC_COMA_LO 6
`define TMC_COMB_HI 5
`define TMC_COMB_LO 4
`define TMC_WGM_HI 1
`define TMC_WGM_LO 0

// control register fields
`define TMC_WGM2_BIT 3
`define TMC_CS_HI 2
`define TMC_CS_LO 0

// flag register fields, write one to clear
`define TMC_OVF_BIT 0
`define TMC_CFA_BIT 1

// reset values
`define TMC_REG_RST 8'h00
`define TMC_FLG_RST 1'b0

// count limits
`define TMC_MAX 8'hFF
`define TMC_BOTTOM 8'h00

// prescaler masks: tick when all masked bits are one
`define TMC_DIV8_M 10'h007
`define TMC_DIV64_M 10'h03F
`define TMC_DIV256_M 10'h0FF
`define TMC_DIV1024_M 10'h3FF

`endif

// ===== tmc_timer.v
// waveform timer: mode decode, counter, compare units and apb registers
//////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - all logic on pclk; prescaled tick only qualifies counting, flags, waveform actions and pwm compare updates
// - nonzero channel A mode overrides pin, except code 1 in pwm without top bit and reserved modes 4,6; driver enabled by direction bit
// - nonzero channel B mode overrides pin, except code 1 in pwm and reserved modes 4,6; driver enabled by direction bit
// - non-pwm channel A: 0 off, 1 toggle, 2 clear, 3 set on match
// - fast pwm A: 1 off or toggle by top bit; 2/3 match vs bottom
// - fast pwm: compare equal top with upper bit set acts only at bottom
// - phase pwm A: 1 off or toggle; 2 clear up set down; 3 opposite
// - phase pwm: compare equal top with upper bit set acts at top
// - non-pwm channel B: 0 off, 1 toggle, 2 clear, 3 set on match
// - fast pwm B: 1 reserved; 2 clear match set bottom; 3 inverse
// - phase pwm B: 1 reserved; 2 clear up set down; 3 reversed
// - bits 3 and 2 of waveform output control always read zero
// - three-bit mode from two low bits plus top bit in control register
// - modes 0,1,3 top 0xFF; 2,5,7 top compare A; 4,6 reserved
// - compare update immediate, at top in phase pwm, bottom in fast pwm
// - overflow at max in 0,2,3; bottom in phase pwm; top in mode 7
// - clear-on-match and mode 7: match A sets flag and clears counter
// - counter counts and flags set only on prescaled tick cycles; apb writes load the count or clear flags on any pclk
// - prescaler divides by 1, 8, 64, 256 or 1024
//////////////////////////////////////////////////////////////////////////
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "tmc_map.vh"

module tmc_timer (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire channel_a_wave_out,
	output wire channel_a_wave_oe,
	output wire channel_a_override,
	output wire channel_b_wave_out,
	output wire channel_b_wave_oe,
	output wire channel_b_override,
	output wire overflow_flag,
	output wire compare_a_flag,
	output wire compare_b_flag
);

localparam [2:0] M_NORMAL = 3'd0;
localparam [2:0] M_PC_FF = 3'd1;
localparam [2:0] M_CTC = 3'd2;
localparam [2:0] M_FAST_FF = 3'd3;
localparam [2:0] M_RSV4 = 3'd4;
localparam [2:0] M_PC_A = 3'd5;
localparam [2:0] M_RSV6 = 3'd6;
localparam [2:0] M_FAST_A = 3'd7;

//////////////////////////////////////////////////////////////////////////
// apb slave, one wait state

reg pready_q;
reg pslverr_q;
reg [31:0] prdata_q;
reg [7:0] woc_q;
reg [3:0] ctl_q;
reg [7:0] cnt_q;
reg [7:0] cmpa_buf_q;
reg [7:0] cmpb_buf_q;
reg [7:0] cmpa_q;
reg [7:0] cmpb_q;
reg [1:0] dir_q;
reg ovf_q;
reg down_q;
reg block_q;
reg [9:0] presc_q;
reg [31:0] rdata_d;
reg hit_d;
wire [2:0] flags;

wire setup = psel & penable & ~pready_q;
wire acc = psel & penable & pready_q;
wire wr = acc & pwrite;
wire wr_woc = wr & (paddr == `TMC_WOC_OFS);
wire wr_ctl = wr & (paddr == `TMC_CTL_OFS);
wire wr_cnt = wr & (paddr == `TMC_CNT_OFS);
wire wr_cmpa = wr & (paddr == `TMC_CMPA_OFS);
wire wr_cmpb = wr & (paddr == `TMC_CMPB_OFS);
wire wr_flg = wr & (paddr == `TMC_FLG_OFS);
wire wr_dir = wr & (paddr == `TMC_DIR_OFS);

always @* begin
	rdata_d = 32'h0000_0000;
	hit_d = 1'b1;
	case (paddr)
		// reserved bits stay zero on read
		`TMC_WOC_OFS: rdata_d[7:0] = {woc_q[7:4], 2'b00, woc_q[1:0]};
		`TMC_CTL_OFS: rdata_d[3:0] = ctl_q;
		`TMC_CNT_OFS: rdata_d[7:0] = cnt_q;
		`TMC_CMPA_OFS: rdata_d[7:0] = cmpa_buf_q;
		`TMC_CMPB_OFS: rdata_d[7:0] = cmpb_buf_q;
		`TMC_FLG_OFS: rdata_d[2:0] = flags;
		`TMC_DIR_OFS: rdata_d[1:0] = dir_q;
		default: hit_d = 1'b0;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready_q <= 1'b0;
		pslverr_q <= 1'b0;
		prdata_q <= 32'h0000_0000;
	end else begin
		pready_q <= setup;
		pslverr_q <= setup & ~hit_d;
		prdata_q <= (setup & ~pwrite) ? rdata_d : 32'h0000_0000;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		woc_q <= `TMC_REG_RST;
		ctl_q <= 4'h0;
		cmpa_buf_q <= `TMC_REG_RST;
		cmpb_buf_q <= `TMC_REG_RST;
		dir_q <= 2'b00;
	end else begin
		if (wr_woc)
			woc_q <= {pwdata[7:4], 2'b00, pwdata[1:0]};
		if (wr_ctl)
			ctl_q <= pwdata[3:0];
		if (wr_cmpa)
			cmpa_buf_q <= pwdata[7:0];
		if (wr_cmpb)
			cmpb_buf_q <= pwdata[7:0];
		if (wr_dir)
			dir_q <= pwdata[1:0];
	end
end

//////////////////////////////////////////////////////////////////////////
// mode decode

wire [2:0] mode = {ctl_q[`TMC_WGM2_BIT], woc_q[1:0]};
wire [2:0] cs = ctl_q[`TMC_CS_HI:`TMC_CS_LO];
wire is_fast = (mode == M_FAST_FF) | (mode == M_FAST_A);
wire is_pc = (mode == M_PC_FF) | (mode == M_PC_A);
wire is_np = (mode == M_NORMAL) | (mode == M_CTC);
wire top_a = (mode == M_CTC) | (mode == M_PC_A) | (mode == M_FAST_A);
wire [7:0] top = top_a ? cmpa_q : `TMC_MAX;

//////////////////////////////////////////////////////////////////////////
// prescaler; external clock selects count nothing, no pin here

reg tick;
always @* begin
	case (cs)
		3'd1: tick = 1'b1;
		3'd2: tick = (presc_q & `TMC_DIV8_M) == `TMC_DIV8_M;
		3'd3: tick = (presc_q & `TMC_DIV64_M) == `TMC_DIV64_M;
		3'd4: tick = (presc_q & `TMC_DIV256_M) == `TMC_DIV256_M;
		3'd5: tick = (presc_q & `TMC_DIV1024_M) == `TMC_DIV1024_M;
		default: tick = 1'b0;
	endcase
end

// tick is an enable on pclk, never a clock of its own
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		presc_q <= 10'h000;
	else if (cs == 3'd0)
		presc_q <= 10'h000;
	else
		presc_q <= presc_q + 10'h001;
end

//////////////////////////////////////////////////////////////////////////
// counter

wire at_top = tick & (cnt_q == top);
wire at_max = tick & (cnt_q == `TMC_MAX);
wire pc_bot = tick & down_q & (cnt_q == `TMC_BOTTOM);
wire pc_top = tick & ~down_q & (cnt_q == top);

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cnt_q <= `TMC_BOTTOM;
		down_q <= 1'b0;
		block_q <= 1'b0;
	end else if (wr_cnt) begin
		// a written count blocks the match on the next tick
		cnt_q <= pwdata[7:0];
		block_q <= 1'b1;
	end else if (tick) begin
		block_q <= 1'b0;
		case (mode)
			M_CTC, M_FAST_FF, M_FAST_A: begin
				if (cnt_q == top)
					cnt_q <= `TMC_BOTTOM;
				else
					cnt_q <= cnt_q + 8'h01;
			end
			M_PC_FF, M_PC_A: begin
				if (!down_q && cnt_q == top) begin
					down_q <= 1'b1;
					cnt_q <= cnt_q - 8'h01;
				end else if (down_q && cnt_q == `TMC_BOTTOM) begin
					down_q <= 1'b0;
					cnt_q <= cnt_q + 8'h01;
				end else if (down_q)
					cnt_q <= cnt_q - 8'h01;
				else
					cnt_q <= cnt_q + 8'h01;
			end
			default: begin
				// normal and reserved modes free-run up
				down_q <= 1'b0;
				cnt_q <= cnt_q + 8'h01;
			end
		endcase
	end
end

//////////////////////////////////////////////////////////////////////////
// compare double buffer

wire upd = is_fast ? at_top : is_pc ? pc_top : 1'b1;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cmpa_q <= `TMC_REG_RST;
		cmpb_q <= `TMC_REG_RST;
	end else if (upd) begin
		cmpa_q <= cmpa_buf_q;
		cmpb_q <= cmpb_buf_q;
	end
end

//////////////////////////////////////////////////////////////////////////
// overflow flag, set wins over a write-one clear

reg ovf_set;
always @* begin
	case (mode)
		M_NORMAL, M_CTC, M_FAST_FF: ovf_set = at_max;
		M_PC_FF, M_PC_A: ovf_set = pc_bot;
		M_FAST_A: ovf_set = at_top;
		default: ovf_set = at_max;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		ovf_q <= `TMC_FLG_RST;
	else if (ovf_set)
		ovf_q <= 1'b1;
	else if (wr_flg && pwdata[`TMC_OVF_BIT])
		ovf_q <= 1'b0;
end

assign flags[`TMC_OVF_BIT] = ovf_q;

//////////////////////////////////////////////////////////////////////////
// compare units, index 0 is channel A, 1 is channel B

genvar i;
generate
	for (i = 0; i < 2; i = i + 1) begin : g_ch
		wire [1:0] com = (i == 0) ? woc_q[7:6] : woc_q[5:4];
		wire [7:0] ocr = (i == 0) ? cmpa_q : cmpb_q;
		wire match = tick & (cnt_q == ocr) & ~block_q;
		wire special = com[1] & (ocr == top);
		// up-count action: clear for code 2, set for code 3
		wire up_set = com[0];
		reg wave_q;
		reg conn_q;
		reg oe_q;
		reg flag_q;
		reg conn;
		reg act;
		reg nxt;

		always @* begin
			conn = 1'b0;
			act = 1'b0;
			nxt = wave_q;
			case (mode)
				M_NORMAL, M_CTC: begin
					conn = com != 2'b00;
					if (match) begin
						act = 1'b1;
						nxt = (com == 2'b01) ? ~wave_q : com[0];
					end
				end
				M_FAST_FF, M_FAST_A: begin
					if (com == 2'b01) begin
						// toggle only for A with top bit set
						conn = (i == 0) & ctl_q[`TMC_WGM2_BIT];
						if (conn && match) begin
							act = 1'b1;
							nxt = ~wave_q;
						end
					end else if (com[1]) begin
						conn = 1'b1;
						if (at_top) begin
							act = 1'b1;
							nxt = ~up_set;
						end else if (match && !special) begin
							act = 1'b1;
							nxt = up_set;
						end
					end
				end
				M_PC_FF, M_PC_A: begin
					if (com == 2'b01) begin
						conn = (i == 0) & ctl_q[`TMC_WGM2_BIT];
						if (conn && match) begin
							act = 1'b1;
							nxt = ~wave_q;
						end
					end else if (com[1]) begin
						conn = 1'b1;
						if (special) begin
							if (pc_top) begin
								// flat level: compare at top stays high for code 2, low for code 3
								act = 1'b1;
								nxt = ~up_set;
							end
						end else if (match) begin
							act = 1'b1;
							nxt = down_q ? ~up_set : up_set;
						end
					end
				end
				default: conn = 1'b0;
			endcase
		end

		always @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				wave_q <= 1'b0;
				conn_q <= 1'b0;
				oe_q <= 1'b0;
				flag_q <= `TMC_FLG_RST;
			end else begin
				if (act)
					wave_q <= nxt;
				conn_q <= conn;
				oe_q <= conn & dir_q[i];
				if (match)
					flag_q <= 1'b1;
				else if (wr_flg && pwdata[`TMC_CFA_BIT + i])
					flag_q <= 1'b0;
			end
		end

		assign flags[`TMC_CFA_BIT + i] = flag_q;
	end
endgenerate

//////////////////////////////////////////////////////////////////////////
// outputs, all from flops

assign prdata = prdata_q;
assign pready = pready_q;
assign pslverr = pslverr_q;
assign channel_a_wave_out = g_ch[0].wave_q;
assign channel_a_wave_oe = g_ch[0].oe_q;
assign channel_a_override = g_ch[0].conn_q;
assign channel_b_wave_out = g_ch[1].wave_q;
assign channel_b_wave_oe = g_ch[1].oe_q;
assign channel_b_override = g_ch[1].conn_q;
assign overflow_flag = ovf_q;
assign compare_a_flag = g_ch[0].flag_q;
assign compare_b_flag = g_ch[1].flag_q;

endmodule // tmc_timer

// ===== tmc_monitor.sv
// assertion checker on the waveform timer ports
`timescale 1ns/1ns
module tmc_monitor (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input logic channel_a_override,
	input logic channel_a_wave_oe,
	input logic channel_b_override,
	input logic channel_b_wave_oe,
	input logic overflow_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	//////////////////////////////////////////////////////////////////
	sequence s_wait;
		psel && penable && !pready ##1 pready;
	endsequence
	sequence s_woc_wr;
		pready && pwrite && paddr == 8'h24;
	endsequence
	a_one_wait: assert property ($rose(penable) && psel |-> s_wait)
		else $error("pready not after one wait state");
	a_ready_drop: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_idle_zero: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rsvd_zero: assert property (s_woc_wr or (pready && !pwrite &&
		paddr == 8'h24) |-> prdata[3:2] == 2'h0)
		else $error("reserved bits not zero");
	a_oe_a_ovr: assert property (channel_a_wave_oe |-> channel_a_override)
		else $error("channel a driven without override");
	a_oe_b_ovr: assert property (channel_b_wave_oe |-> channel_b_override)
		else $error("channel b driven without override");
	a_code0_off: assert property (s_woc_wr and pwdata[7:6] == 2'h0
		|-> ##2 !channel_a_override)
		else $error("code zero left channel a connected");
	a_ovf_sticky: assert property (overflow_flag && !(pready && pwrite &&
		paddr == 8'h38 && pwdata[0]) |=> overflow_flag)
		else $error("overflow flag lost");
endmodule // tmc_monitor

bind tmc_timer tmc_monitor u_mon (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.channel_a_override, .channel_a_wave_oe, .channel_b_override,
	.channel_b_wave_oe, .overflow_flag);

// ===== tmc_pin.sv
// port pin model for one compare waveform output
`timescale 1ns/1ns
module tmc_pin (
	input logic wave,
	input logic oe,
	output logic level
);
	// released pin sits on its pull-up, so a stale low never shows
	assign level = oe ? wave : 1'b1;
endmodule // tmc_pin

// ===== tmc_timer_tb.sv
// self-checking bench for the waveform timer
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
	miscompares++; $display("wrong value at %0t: %h not %h", \
	$time, a, b); end end
module tmc_timer_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic wa, oa, wb, ob, ova, ovb, pin_a, pin_b, err;
	logic fo, fa, fb;
	int miscompares = 0;
	int tests_run = 0;
	int h, hb;
	//////////////////////////////////////////////////////////////////
	tmc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .channel_a_wave_out(wa),
		.channel_a_wave_oe(oa), .channel_a_override(ova),
		.channel_b_wave_out(wb), .channel_b_wave_oe(ob),
		.channel_b_override(ovb), .overflow_flag(fo),
		.compare_a_flag(fa), .compare_b_flag(fb));
	tmc_pin u_pa (.wave(wa), .oe(oa), .level(pin_a));
	tmc_pin u_pb (.wave(wb), .oe(ob), .level(pin_b));
	//////////////////////////////////////////////////////////////////
	task test_done;
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// idle cycle first, so no signal is assigned twice in one step
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task hi(input int n);
		h = 0;
		hb = 0;
		repeat (n) begin
			@(negedge pclk);
			h += pin_a;
			hb += pin_b;
		end
	endtask
	//////////////////////////////////////////////////////////////////
	initial begin
		pclk = 0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#2500000;
		miscompares++;
		test_done;
	end
	initial begin
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, 8'h24, 0);
		`CHK(rd, 32'h0)
		xfer(1, 8'h24, 32'hFF);
		xfer(0, 8'h24, 0);
		`CHK(rd, 32'hF3)
		xfer(0, 8'h40, 0);
		`CHK({err, rd}, {1'b1, 32'h0})
		// normal mode: wrap past max sets overflow and both matches
		xfer(1, 8'h24, 0);
		xfer(1, 8'h2C, 32'hF0);
		xfer(1, 8'h28, 1);
		repeat (40) @(posedge pclk);
		xfer(0, 8'h38, 0);
		`CHK(rd, 32'h7)
		`CHK({fo, fa, fb}, 3'h7)
		// stopped clock must freeze the count
		xfer(1, 8'h28, 0);
		xfer(1, 8'h2C, 32'h10);
		repeat (50) @(posedge pclk);
		xfer(0, 8'h2C, 0);
		`CHK(rd, 32'h10)
		// divide by eight: one count per eight pclk cycles
		xfer(1, 8'h28, 2);
		repeat (80) @(posedge pclk);
		xfer(0, 8'h2C, 0);
		`CHK(rd, 32'h1A)
		xfer(1, 8'h28, 0);
		// clear-on-match: counter never passes compare a
		xfer(1, 8'h2C, 0);
		xfer(1, 8'h30, 3);
		xfer(1, 8'h24, 2);
		xfer(1, 8'h38, 7);
		xfer(1, 8'h28, 1);
		repeat (20) @(posedge pclk);
		xfer(0, 8'h38, 0);
		`CHK(rd[1:0], 2'h2)
		xfer(0, 8'h2C, 0);
		`CHK(rd[7:2], 6'h0)
		// fast pwm, compare at top: level fixed, b code 1 stays off
		xfer(1, 8'h30, 32'hFF);
		xfer(1, 8'h3C, 3);
		xfer(1, 8'h24, 32'h93);
		repeat (600) @(posedge pclk);
		hi(300);
		`CHK(h, 300)
		`CHK(ovb, 1'b0)
		xfer(1, 8'h24, 32'hC3);
		repeat (300) @(posedge pclk);
		hi(300);
		`CHK(h, 0)
		xfer(1, 8'h3C, 0);
		repeat (3) @(posedge pclk);
		`CHK({ova, pin_a}, 2'h3)
		// phase pwm: compare at top stays high, mid compare sets duty
		xfer(1, 8'h3C, 3);
		xfer(1, 8'h24, 32'h81);
		repeat (600) @(posedge pclk);
		hi(300);
		`CHK(h, 300)
		xfer(1, 8'h30, 32'h80);
		xfer(1, 8'h34, 32'h80);
		xfer(1, 8'h24, 32'hB1);
		repeat (1100) @(posedge pclk);
		hi(510);
		`CHK(h, 256)
		`CHK(hb, 254)
		// mode 7: compare a is top, a toggles, overflow at top
		xfer(1, 8'h30, 9);
		xfer(1, 8'h24, 32'h43);
		xfer(1, 8'h28, 32'h9);
		repeat (600) @(posedge pclk);
		xfer(1, 8'h38, 7);
		repeat (30) @(posedge pclk);
		xfer(0, 8'h38, 0);
		`CHK(rd, 32'h3)
		hi(200);
		`CHK(h, 100)
		// reserved mode 4 keeps channel a disconnected
		xfer(1, 8'h24, 32'h80);
		xfer(1, 8'h28, 32'h9);
		repeat (3) @(posedge pclk);
		`CHK(ova, 1'b0)
		test_done;
	end
endmodule // tmc_timer_tb
